/* File: hdl/ccr_regs.vh */
// Purpose: Register map and field layout of the comparator control register block.
// Assumes: Classic Wishbone slave with 32-bit data and word-aligned addresses.
// Notes: The printed offset 0x9E is not a multiple of four, so it is a word index.
`ifndef CCR_REGS_VH
`define CCR_REGS_VH
`define CCR_ADDR_W 10
`define CCR_CTRL_INDEX 10'h09E
`define CCR_CTRL_ADDR 10'h278
`define CCR_BIT_ENABLE 7
`define CCR_BIT_OUT 6
`define CCR_BIT_RISE 5
`define CCR_BIT_FALL 4
`define CCR_POS_HI 3
`define CCR_POS_LO 2
`define CCR_NEG_HI 1
`define CCR_NEG_LO 0
`define CCR_CTRL_RESET 8'h00
`define CCR_HYST_2MV 2'h0
`define CCR_HYST_10MV 2'h2
`define CCR_HYST_10MV_ALT 2'h3
`endif

/* File: hdl/ccr_edge_detect.v */
// Purpose: Registers the comparator level and marks its rising and falling edges.
// Assumes: The comparator level is synchronous to clk_i.
// Notes: Rising edges are only reported while enabled; clearing the enable while the level is high reports a falling edge.
`timescale 1ns/100ps
module ccr_edge_detect (
	input wire clk_i, // System clock.
	input wire rst_i, // Synchronous reset, active high.
	input wire enable_i, // Comparator enabled.
	input wire level_i, // Raw comparator output.
	output reg state_o, // Registered comparator output.
	output wire rise_o, // One-cycle rising-edge pulse.
	output wire fall_o // One-cycle falling-edge pulse.
);
	wire next_state;

	assign next_state = enable_i & level_i;

	always @(posedge clk_i) begin
		if (rst_i) begin
			state_o <= 1'b0;
		end else begin
			state_o <= next_state;
		end
	end

	assign rise_o = next_state & ~state_o;
	assign fall_o = ~next_state & state_o;
endmodule // ccr_edge_detect

/* File: hdl/ccr_comparator_ctrl.v */
// Purpose: Comparator control and status register behind a classic Wishbone slave.
// Assumes: Comparator level arrives synchronous to clk_i; 32-bit Wishbone data.
// Notes: One register at word index 0x9E; byte lane 0 holds all eight bits.
// How it works
// - Bit 7 enables the comparator.
// - Bit 6 reads the registered comparator output, gated by bit 7.
// - Bit 5 sticky flag set on rising edge.
// - Bit 4 sticky flag set on falling edge.
// - Bits 3:2 select positive hysteresis level.
// - Bits 1:0 select negative hysteresis level.
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/100ps
`include "ccr_regs.vh"
module ccr_comparator_ctrl (
	input wire clk_i, // System clock, 40 MHz.
	input wire rst_i, // Synchronous reset, active high.
	input wire wb_cyc_i, // Wishbone cycle.
	input wire wb_stb_i, // Wishbone strobe.
	input wire wb_we_i, // Wishbone write enable.
	input wire [31:0] wb_adr_i, // Wishbone byte address.
	input wire [3:0] wb_sel_i, // Wishbone byte selects.
	input wire [31:0] wb_dat_i, // Wishbone write data.
	output reg [31:0] wb_dat_o, // Wishbone read data.
	output reg wb_ack_o, // Wishbone acknowledge.
	output reg wb_err_o, // Wishbone error for unmapped address.
	input wire cmp_level_i, // Comparator output from the analog stage.
	output wire cmp_enable_o, // Comparator enable to the analog stage.
	output wire [1:0] cmp_pos_hyst_sel_o, // Positive hysteresis select.
	output wire [1:0] cmp_neg_hyst_sel_o // Negative hysteresis select.
);
	reg cmp_enable;
	reg cmp_rise_flag;
	reg cmp_fall_flag;
	reg [1:0] cmp_pos_hyst_sel;
	reg [1:0] cmp_neg_hyst_sel;
	wire cmp_output_state;
	wire rise_evt;
	wire fall_evt;
	wire req;
	wire hit;
	wire wr_lane0;
	wire [7:0] reg_value;

	ccr_edge_detect u_edge (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.enable_i(cmp_enable),
		.level_i(cmp_level_i),
		.state_o(cmp_output_state),
		.rise_o(rise_evt),
		.fall_o(fall_evt)
	);

	// One-cycle answer; the request edge is taken only while no ack or error stands.
	assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
	assign hit = (wb_adr_i[31:2] == {20'h00000, `CCR_CTRL_INDEX}) & (wb_adr_i[1:0] == 2'h0);
	assign wr_lane0 = req & hit & wb_we_i & wb_sel_i[0];

	assign reg_value = {cmp_enable, cmp_output_state, cmp_rise_flag, cmp_fall_flag,
		cmp_pos_hyst_sel, cmp_neg_hyst_sel};

	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= req & hit;
			wb_err_o <= req & ~hit;
			wb_dat_o <= (req & hit & ~wb_we_i) ? {24'h000000, reg_value} : 32'h00000000;
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			cmp_enable <= 1'b0;
			cmp_pos_hyst_sel <= `CCR_HYST_2MV;
			cmp_neg_hyst_sel <= `CCR_HYST_2MV;
		end else if (wr_lane0) begin
			cmp_enable <= wb_dat_i[`CCR_BIT_ENABLE];
			cmp_pos_hyst_sel <= wb_dat_i[`CCR_POS_HI:`CCR_POS_LO];
			cmp_neg_hyst_sel <= wb_dat_i[`CCR_NEG_HI:`CCR_NEG_LO];
		end
	end

	// A set in the same cycle as a clearing write wins.
	always @(posedge clk_i) begin
		if (rst_i) begin
			cmp_rise_flag <= 1'b0;
			cmp_fall_flag <= 1'b0;
		end else begin
			if (rise_evt) begin
				cmp_rise_flag <= 1'b1;
			end else if (wr_lane0 & ~wb_dat_i[`CCR_BIT_RISE]) begin
				cmp_rise_flag <= 1'b0;
			end
			if (fall_evt) begin
				cmp_fall_flag <= 1'b1;
			end else if (wr_lane0 & ~wb_dat_i[`CCR_BIT_FALL]) begin
				cmp_fall_flag <= 1'b0;
			end
		end
	end

	assign cmp_enable_o = cmp_enable;
	assign cmp_pos_hyst_sel_o = cmp_pos_hyst_sel;
	assign cmp_neg_hyst_sel_o = cmp_neg_hyst_sel;
endmodule // ccr_comparator_ctrl

/* File: test/ccr_chk.sv */
// Purpose: port checks. Assumes: one-cycle ack. Notes: none.
`timescale 1ns/100ps
module ccr_chk(input wire clk_i,rst_i,wb_we_i,wb_ack_o,cmp_level_i,cmp_enable_o,
input wire [3:0] wb_sel_i,input wire [31:0] wb_dat_i,wb_dat_o,
input wire [1:0] cmp_pos_hyst_sel_o,cmp_neg_hyst_sel_o);
wire l=cmp_level_i;
default clocking @(posedge clk_i);endclocking
default disable iff(rst_i);
sequence s_wr;wb_ack_o&&$past(wb_we_i&&wb_sel_i[0]);endsequence
sequence s_rd;cmp_enable_o[*4]##1 wb_ack_o&&!$past(wb_we_i);endsequence
property p_en;s_wr|->cmp_enable_o==wb_dat_i[7];endproperty
a_en:assert property(p_en)else $error("en");
property p_out;s_rd|->wb_dat_o[6]==$past(l,2);endproperty
a_out:assert property(p_out)else $error("out");
property p_ri;s_rd##0($past(l,3)&&!$past(l,4))|->wb_dat_o[5];endproperty
a_ri:assert property(p_ri)else $error("rise");
property p_fa;s_rd##0(!$past(l,3)&&$past(l,4))|->wb_dat_o[4];endproperty
a_fa:assert property(p_fa)else $error("fall");
property p_hp;s_wr|->cmp_pos_hyst_sel_o==wb_dat_i[3:2];endproperty
a_hp:assert property(p_hp)else $error("pos");
property p_hn;s_wr|->cmp_neg_hyst_sel_o==wb_dat_i[1:0];endproperty
a_hn:assert property(p_hn)else $error("neg");
endmodule // ccr_chk
bind ccr_comparator_ctrl ccr_chk u_ccr_chk(.*);

/* File: test/tb_top.sv */
// Purpose: bench. Assumes: one-cycle ack. Notes: none.
`timescale 1ns/100ps
module tb_top;
localparam A=32'h278;
reg clk_i=0,rst_i=1,wb_cyc_i=0,wb_we_i=0,cmp_level_i=0;
reg [3:0] wb_sel_i=4'hF;
reg [31:0] wb_adr_i=0,wb_dat_i=0;
reg [32:0] q;
wire [31:0] wb_dat_o;
wire wb_ack_o,wb_err_o,cmp_enable_o;
wire [1:0] cmp_pos_hyst_sel_o,cmp_neg_hyst_sel_o;
integer n_mismatch=0,checks=0,n=0,m,i,mdl=0,lvl=0;
always #12.5 clk_i=~clk_i;
ccr_comparator_ctrl u_ccr_comparator_ctrl(.*,.wb_stb_i(wb_cyc_i));
task chk(input [32:0] s,e);checks++;
if(s!==e)begin n_mismatch++;$display("MISMATCH %0t %h %h",$time,s,e);end
endtask
task upd(input [7:0] v);reg o;o=v[7]&lvl[0];
mdl={v[7],o,v[5]|(o&~mdl[6]),v[4]|(~o&mdl[6]),v[3:0]};
endtask
task stop_test;$display("checks %0d mismatches %0d",checks,n_mismatch);
if(n_mismatch==0&&checks>0)$display("[ PASS ]");
else $display("[ FAIL ]");
$finish;
endtask
always @(posedge clk_i)if(++n>3000)begin n_mismatch++;stop_test;end
task bus(input w,input [31:0] a,d);
@(posedge clk_i);{wb_cyc_i,wb_we_i,wb_adr_i,wb_dat_i}<={1'h1,w,a,d};
@(posedge clk_i);while(!(wb_ack_o|wb_err_o))@(posedge clk_i);
q={wb_err_o,wb_dat_o};wb_cyc_i<=0;
if(w&&!wb_err_o&&wb_sel_i[0])upd({d[7],1'b0,mdl[5]&d[5],mdl[4]&d[4],d[3:0]});
endtask
task r;bus(0,A,0);chk(q,mdl);endtask
task lr(input v);cmp_level_i<=v;lvl=v;upd(mdl[7:0]);@(posedge clk_i);r;endtask
initial begin
m=$urandom(32'hB2FA);repeat(16)@(posedge clk_i);rst_i<=0;
r;chk(q,0);
$display("test reset value done");
for(i=0;i<4;i++)begin m=$urandom&8'h80|i*5;bus(1,A,m|8'h70);r;chk(q,m);end
chk({cmp_enable_o,cmp_pos_hyst_sel_o,cmp_neg_hyst_sel_o},{m[7],m[3:0]});
$display("test field writes done");
wb_sel_i<=4'hE;bus(1,A,0);wb_sel_i<=4'hF;bus(1,A+4,0);chk(q,33'h100000000);r;chk(q,m);
$display("test refused accesses done");
bus(1,A,8'h80);lr(1);chk(q,8'hE0);
lr(0);chk(q,8'hB0);
$display("test edge flags done");
bus(1,A,8'hA0);r;chk(q,8'hA0);
$display("test flag clear done");
stop_test;
end
endmodule // tb_top
